// [core/emr_pkg.sv]
// package: register map, reset values and carrier types for emr_regs
package emr_pkg;

	// ------------------------------------------------------------
	// register indices (byte address is four times the index)
	// ------------------------------------------------------------
	localparam int IDX_W = 10;
	localparam logic [IDX_W-1:0] IDX_MGMT_STATUS = 10'h03A;
	localparam logic [IDX_W-1:0] IDX_MGMT_CMD = 10'h03B;
	localparam logic [IDX_W-1:0] IDX_PHY_DATA_LOW = 10'h03C;
	localparam logic [IDX_W-1:0] IDX_PHY_DATA_HIGH = 10'h03D;
	localparam logic [IDX_W-1:0] IDX_PHY_REG_SEL = 10'h03E;
	localparam logic [IDX_W-1:0] IDX_PHY_UNIT_SEL = 10'h03F;
	localparam logic [IDX_W-1:0] IDX_TX_POLL_PERIOD = 10'h040;
	localparam logic [IDX_W-1:0] IDX_MAC_RESET_CTL = 10'h041;
	localparam logic [IDX_W-1:0] IDX_TX_LOWER_LOW = 10'h042;

	// ------------------------------------------------------------
	// reset values and field positions
	// ------------------------------------------------------------
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] RST_MAC_RESET_CTL = 8'h20;
	localparam int RC_GLOBAL = 5;
	localparam int RC_TX_FN = 4;
	localparam int RC_RX_FN = 3;
	localparam int RC_TX_CTL = 2;
	localparam int RC_RX_CTL = 1;
	localparam int RC_MGMT = 0;
	localparam int CMD_TRIGGER = 7;
	localparam int TLB_LSB = 5;

	// ------------------------------------------------------------
	// timing, management frame fields and response codes
	// ------------------------------------------------------------
	localparam int POLL_PRESCALE = 256;
	localparam int MDC_HALF_CYCLES = 2;
	localparam int FRAME_BITS = 64;
	localparam logic [31:0] MDIO_PREAMBLE = 32'hFFFF_FFFF;
	localparam logic [1:0] MDIO_SOF = 2'h1;
	localparam logic [1:0] MDIO_OP_WRITE = 2'h1;
	localparam logic [1:0] MDIO_TA = 2'h2;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ------------------------------------------------------------
	// carrier types
	// ------------------------------------------------------------
	typedef struct packed {
		logic tx_fn;
		logic rx_fn;
		logic tx_ctl;
		logic rx_ctl;
		logic mgmt;
	} emr_fn_reset_type;

endpackage

// [core/emr_poll_timer.sv]
// transmit descriptor polling timer: prescaler and period counter
module emr_poll_timer #(
	parameter int PRESCALE = emr_pkg::POLL_PRESCALE
) (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic [7:0] period,
	input wire logic kick,
	output logic check_r
);

	localparam int PW = $clog2(PRESCALE);

	logic [PW-1:0] pre_r;
	logic tick_r;
	logic [7:0] cnt_r;

	// ------------------------------------------------------------
	// prescaler
	// ------------------------------------------------------------
	// free running so the first period after a write may be short by
	// up to one tick; cheaper than restarting the prescaler
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			pre_r <= '0;
			tick_r <= 1'b0;
		end else begin
			pre_r <= pre_r + 1'b1; // see [RULE4]
			tick_r <= (pre_r == PW'(PRESCALE - 1));
		end
	end

	// ------------------------------------------------------------
	// period counter
	// ------------------------------------------------------------
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			cnt_r <= 8'h00;
			check_r <= 1'b0;
		end else begin
			check_r <= 1'b0;
			if (kick) begin
				cnt_r <= 8'h00;
				check_r <= 1'b1; // see [RULE5]
			end else if (period == 8'h00) begin
				cnt_r <= 8'h00; // see [RULE7]
			end else if (tick_r) begin
				if (cnt_r + 8'h01 >= period) begin
					cnt_r <= 8'h00;
					check_r <= 1'b1; // see [RULE6]
				end else begin
					cnt_r <= cnt_r + 8'h01;
				end
			end
		end
	end

endmodule

// [core/emr_regs.sv]
// ethernet mac management, polling and reset control register slice
// Function
// [RULE1] high byte holds phy data bits 15..8
// [RULE2] five-bit phy register select, upper zero
// [RULE3] five-bit phy unit select, upper zero
// [RULE4] poll tick is clock divided by 256
// [RULE5] poll register write triggers descriptor check
// [RULE6] recheck every tick times poll value
// [RULE7] zero period stops timer and new sends
// [RULE8] transmission underway finishes after zero period
// [RULE9] reset bits stay until software changes them
// [RULE10] bit 5 resets all functions, set at reset
// [RULE11] bits 4,3,2 reset tx, rx, tx control
// [RULE12] bit 1 resets receive control function
// [RULE13] bit 0 resets management function
// [RULE14] reset bits 7..6 read zero
// [RULE15] lower bound low byte, bits 4..0 zero
// [RULE16] software points lower bound at tx buffer
// [RULE17] phy write frame carries unit, register, data
// [RULE18] trigger rising edge starts idle write, self-clears
// [RULE19] writes to fixed bits are ignored
//
// Added by the designer: the AXI4-Lite slave port.
module emr_regs #(
	parameter int MDC_HALF = emr_pkg::MDC_HALF_CYCLES,
	parameter int PRESCALE = emr_pkg::POLL_PRESCALE
) (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic [11:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [11:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic tx_busy,
	output logic desc_check,
	output logic tx_start_allow_r,
	output emr_pkg::emr_fn_reset_type fn_reset_r,
	output logic [15:0] tx_lower_bound_r,
	output logic mdc_r,
	output logic mdio_out_r,
	output logic mdio_oe_n_r,
	input wire logic mdio_in
);

	typedef enum logic {MG_IDLE, MG_SHIFT} emr_mg_state_type;

	logic aw_have_r;
	logic w_have_r;
	logic [11:0] waddr_r;
	logic [7:0] wbyte_r;
	logic wlane_r;
	logic commit;
	logic [emr_pkg::IDX_W-1:0] widx;
	logic wr_hit;
	logic [7:0] data_low_r;
	logic [7:0] data_high_r;
	logic [4:0] reg_sel_r;
	logic [4:0] unit_sel_r;
	logic [7:0] poll_period_r;
	logic [5:0] rst_ctl_r;
	logic [2:0] tlb_low_r;
	logic poll_kick_r;
	logic trig_wr;
	emr_mg_state_type mg_state_r;
	logic [emr_pkg::FRAME_BITS-1:0] shift_r;
	logic [5:0] bit_cnt_r;
	logic [7:0] div_cnt_r;
	logic mdio_in_unused;

	// ------------------------------------------------------------
	// address decode
	// ------------------------------------------------------------
	function automatic logic map_hit(input logic [11:0] addr);
		logic [emr_pkg::IDX_W-1:0] idx;
		idx = addr[11:2];
		map_hit = (addr[1:0] == 2'h0) &&
			(idx >= emr_pkg::IDX_MGMT_STATUS) &&
			(idx <= emr_pkg::IDX_TX_LOWER_LOW);
	endfunction

	// read mux: fixed and reserved bits come out as zero
	function automatic logic [7:0] read_byte(
		input logic [emr_pkg::IDX_W-1:0] idx);
		unique case (idx)
			emr_pkg::IDX_MGMT_STATUS:
				read_byte = {6'h00, (poll_period_r != 8'h00),
					(mg_state_r == MG_SHIFT)};
			emr_pkg::IDX_MGMT_CMD:
				read_byte = {(mg_state_r == MG_SHIFT), 7'h00};
			emr_pkg::IDX_PHY_DATA_LOW: read_byte = data_low_r;
			emr_pkg::IDX_PHY_DATA_HIGH: read_byte = data_high_r;
			emr_pkg::IDX_PHY_REG_SEL: read_byte = {3'h0, reg_sel_r};
			emr_pkg::IDX_PHY_UNIT_SEL: read_byte = {3'h0, unit_sel_r};
			emr_pkg::IDX_TX_POLL_PERIOD: read_byte = poll_period_r;
			emr_pkg::IDX_MAC_RESET_CTL: read_byte = {2'h0, rst_ctl_r};
			emr_pkg::IDX_TX_LOWER_LOW: read_byte = {tlb_low_r, 5'h00};
			default: read_byte = 8'h00;
		endcase
	endfunction

	// ------------------------------------------------------------
	// write channels
	// ------------------------------------------------------------
	// address and data are taken in either order; one write at a time
	assign commit = aw_have_r && w_have_r && !bvalid;
	assign widx = waddr_r[11:2];
	assign wr_hit = commit && wlane_r && map_hit(waddr_r);

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			aw_have_r <= 1'b0;
			w_have_r <= 1'b0;
			awready <= 1'b1;
			wready <= 1'b1;
			waddr_r <= 12'h000;
			wbyte_r <= 8'h00;
			wlane_r <= 1'b0;
			bvalid <= 1'b0;
			bresp <= emr_pkg::RESP_OKAY;
		end else begin
			if (awvalid && awready) begin
				aw_have_r <= 1'b1;
				awready <= 1'b0;
				waddr_r <= awaddr;
			end
			if (wvalid && wready) begin
				w_have_r <= 1'b1;
				wready <= 1'b0;
				wbyte_r <= wdata[7:0];
				wlane_r <= wstrb[0];
			end
			if (commit) begin
				aw_have_r <= 1'b0;
				w_have_r <= 1'b0;
				bvalid <= 1'b1;
				bresp <= map_hit(waddr_r) ? emr_pkg::RESP_OKAY :
					emr_pkg::RESP_SLVERR;
			end else if (bvalid && bready) begin
				bvalid <= 1'b0;
				awready <= 1'b1;
				wready <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// register storage
	// ------------------------------------------------------------
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			data_low_r <= emr_pkg::RST_ZERO;
			data_high_r <= emr_pkg::RST_ZERO;
			reg_sel_r <= 5'h00;
			unit_sel_r <= 5'h00;
			poll_period_r <= emr_pkg::RST_ZERO;
			rst_ctl_r <= emr_pkg::RST_MAC_RESET_CTL[5:0];
			tlb_low_r <= 3'h0;
		end else if (wr_hit) begin
			unique case (widx)
				emr_pkg::IDX_PHY_DATA_LOW: data_low_r <= wbyte_r;
				emr_pkg::IDX_PHY_DATA_HIGH:
					data_high_r <= wbyte_r; // see [RULE1]
				emr_pkg::IDX_PHY_REG_SEL:
					reg_sel_r <= wbyte_r[4:0]; // see [RULE2] [RULE19]
				emr_pkg::IDX_PHY_UNIT_SEL:
					unit_sel_r <= wbyte_r[4:0]; // see [RULE3] [RULE19]
				emr_pkg::IDX_TX_POLL_PERIOD: poll_period_r <= wbyte_r;
				emr_pkg::IDX_MAC_RESET_CTL:
					rst_ctl_r <= wbyte_r[5:0]; // see [RULE9] [RULE14]
				emr_pkg::IDX_TX_LOWER_LOW:
					tlb_low_r <= wbyte_r[7:emr_pkg::TLB_LSB]; // see [RULE15]
				default: ;
			endcase
		end
	end

	// upper byte of the lower bound lives outside this slice
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			tx_lower_bound_r <= 16'h0000;
		end else begin
			tx_lower_bound_r <= {emr_pkg::RST_ZERO, tlb_low_r, 5'h00}; // see [RULE15]
		end
	end

	// ------------------------------------------------------------
	// read channel
	// ------------------------------------------------------------
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			arready <= 1'b1;
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= emr_pkg::RESP_OKAY;
		end else if (arvalid && arready) begin
			arready <= 1'b0;
			rvalid <= 1'b1;
			rdata <= {24'h00_0000, read_byte(araddr[11:2])};
			rresp <= map_hit(araddr) ? emr_pkg::RESP_OKAY :
				emr_pkg::RESP_SLVERR;
		end else if (rvalid && rready) begin
			rvalid <= 1'b0;
			arready <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// function resets
	// ------------------------------------------------------------
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			fn_reset_r <= '1;
		end else begin
			// global bit widens over all five; the rest map one to one
			fn_reset_r <= emr_pkg::emr_fn_reset_type'( // see [RULE11] [RULE12]
				{5{rst_ctl_r[emr_pkg::RC_GLOBAL]}} | // see [RULE10]
				rst_ctl_r[emr_pkg::RC_TX_FN:emr_pkg::RC_MGMT]); // see [RULE13]
		end
	end

	// ------------------------------------------------------------
	// transmit polling
	// ------------------------------------------------------------
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			poll_kick_r <= 1'b0;
			tx_start_allow_r <= 1'b0;
		end else begin
			poll_kick_r <= wr_hit &&
				(widx == emr_pkg::IDX_TX_POLL_PERIOD); // see [RULE5]
			// a frame already going keeps its permission to the end
			tx_start_allow_r <= (poll_period_r != 8'h00) ||
				(tx_busy && tx_start_allow_r); // see [RULE7] [RULE8]
		end
	end

	emr_poll_timer #(
		.PRESCALE(PRESCALE)
	) u_poll (
		.mclk(mclk),
		.rstn(rstn),
		.period(poll_period_r),
		.kick(poll_kick_r),
		.check_r(desc_check)
	);

	// ------------------------------------------------------------
	// management write engine
	// ------------------------------------------------------------
	// a trigger while busy or in reset is dropped: the bit never stores
	assign trig_wr = wr_hit && (widx == emr_pkg::IDX_MGMT_CMD) &&
		wbyte_r[emr_pkg::CMD_TRIGGER];
	assign mdio_in_unused = mdio_in;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			mg_state_r <= MG_IDLE;
			shift_r <= '0;
			bit_cnt_r <= 6'h00;
			div_cnt_r <= 8'h00;
			mdc_r <= 1'b0;
			mdio_out_r <= 1'b0;
			mdio_oe_n_r <= 1'b1;
		end else if (fn_reset_r.mgmt) begin
			mg_state_r <= MG_IDLE; // see [RULE13]
			mdc_r <= 1'b0;
			mdio_oe_n_r <= 1'b1;
		end else begin
			unique case (mg_state_r)
				MG_IDLE: begin
					if (trig_wr) begin
						mg_state_r <= MG_SHIFT; // see [RULE18]
						shift_r <= {emr_pkg::MDIO_PREAMBLE, emr_pkg::MDIO_SOF,
							emr_pkg::MDIO_OP_WRITE, unit_sel_r, reg_sel_r,
							emr_pkg::MDIO_TA, data_high_r,
							data_low_r}; // see [RULE17]
						mdio_out_r <= 1'b1;
						mdio_oe_n_r <= 1'b0;
						bit_cnt_r <= 6'h00;
						div_cnt_r <= 8'h00;
						mdc_r <= 1'b0;
					end
				end
				MG_SHIFT: begin
					if (div_cnt_r == 8'(MDC_HALF - 1)) begin
						div_cnt_r <= 8'h00;
						mdc_r <= ~mdc_r;
						// data moves on the falling edge, phy samples on rising
						if (mdc_r) begin
							if (bit_cnt_r == 6'(emr_pkg::FRAME_BITS - 1)) begin
								mg_state_r <= MG_IDLE;
								mdio_oe_n_r <= 1'b1;
							end else begin
								bit_cnt_r <= bit_cnt_r + 6'h01;
								shift_r <= {shift_r[62:0], 1'b0};
								mdio_out_r <= shift_r[62];
							end
						end
					end else begin
						div_cnt_r <= div_cnt_r + 8'h01;
					end
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);

	poll_kick_a: assert property ( // see [RULE5]
		(wr_hit && widx == emr_pkg::IDX_TX_POLL_PERIOD) |-> ##2 desc_check)
		else $error("no descriptor check after poll write");
	poll_stop_a: assert property ( // see [RULE7]
		(poll_period_r == 8'h00 && !tx_busy) |=> !tx_start_allow_r)
		else $error("transmit allowed with zero poll period");
	tx_finish_a: assert property ( // see [RULE8]
		(tx_busy && tx_start_allow_r) |=> tx_start_allow_r)
		else $error("running transmission lost its permission");
	global_reset_a: assert property ( // see [RULE10]
		rst_ctl_r[emr_pkg::RC_GLOBAL] |=> (fn_reset_r == '1))
		else $error("global soft reset not applied to all functions");
	mgmt_reset_a: assert property ( // see [RULE13]
		(rst_ctl_r == 6'h01) |=> fn_reset_r.mgmt && !fn_reset_r.tx_fn)
		else $error("management reset bit mapped wrongly");
	reset_hold_a: assert property ( // see [RULE9]
		!wr_hit |=> $stable(rst_ctl_r))
		else $error("reset control changed without a write");

	reg_sel_rd_a: assert property ( // see [RULE2]
		(arvalid && arready &&
			araddr[11:2] == emr_pkg::IDX_PHY_REG_SEL) |=> rdata[7:5] == 3'h0)
		else $error("register select reserved bits not zero");
	unit_sel_rd_a: assert property ( // see [RULE3]
		(arvalid && arready &&
			araddr[11:2] == emr_pkg::IDX_PHY_UNIT_SEL) |=> rdata[7:5] == 3'h0)
		else $error("unit select reserved bits not zero");

	rst_rsvd_rd_a: assert property ( // see [RULE14]
		(arvalid && arready &&
			araddr[11:2] == emr_pkg::IDX_MAC_RESET_CTL) |=> rdata[7:6] == 2'h0)
		else $error("reset control reserved bits not zero");

	tlb_align_a: assert property ( // see [RULE15]
		(arvalid && arready &&
			araddr[11:2] == emr_pkg::IDX_TX_LOWER_LOW) |=> rdata[4:0] == 5'h00)
		else $error("lower bound alignment bits not zero");

	mdio_start_a: assert property ( // see [RULE18]
		(trig_wr && mg_state_r == MG_IDLE && !fn_reset_r.mgmt) |=>
			!mdio_oe_n_r && mdio_out_r && !mdc_r ##1 !mdio_oe_n_r)
		else $error("management write did not start");

endmodule

// [verif/emr_phy_model.sv]
// management-bus phy model: collects one write frame from mdc/mdio
module emr_phy_model (
	input wire logic mdc_r,
	input wire logic mdio_out_r,
	input wire logic mdio_oe_n_r,
	output logic mdio_in,
	output logic [63:0] frame,
	output int nbits
);
	timeunit 1ns;
	timeprecision 100ps;
	// --------------------------------------------------------------
	// wire level and capture
	// --------------------------------------------------------------
	// line is pulled up, the phy never drives it during writes
	assign mdio_in = mdio_oe_n_r ? 1'b1 : mdio_out_r;
	initial frame = 64'h0;
	initial nbits = 0;
	// data is sampled on the rising management clock, msb first
	always @(posedge mdc_r) begin
		if (!mdio_oe_n_r) begin
			frame <= {frame[62:0], mdio_in};
			nbits <= nbits + 1;
		end
	end
endmodule

// [verif/test_emr_regs.sv]
// self-checking bench for the mac register slice
module test_emr_regs;
	timeunit 1ns;
	timeprecision 100ps;
	// --------------------------------------------------------------
	// signals
	// --------------------------------------------------------------
	logic mclk = 0, rstn = 0;
	logic [11:0] awaddr = 0, araddr = 0;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [31:0] wdata = 0;
	logic [3:0] wstrb = 0;
	logic tx_busy = 0;
	logic awready, wready, bvalid, arready, rvalid, desc_check;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic tx_start_allow_r, mdc_r, mdio_out_r, mdio_oe_n_r, mdio_in;
	emr_pkg::emr_fn_reset_type fn_reset_r;
	logic [15:0] tx_lower_bound_r;
	logic [63:0] frame;
	logic [33:0] expq[$];
	logic [1:0] bq[$];
	logic [31:0] seed = 32'h2E34367E;
	int nbits, err_total = 0, comparisons = 0, cyc = 0;
	int pulses = 0, last = 0, gap = 0;
	always #2.5 mclk = ~mclk;
	emr_regs #(.PRESCALE(4)) DUT (.mclk(mclk), .rstn(rstn),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.tx_busy(tx_busy), .desc_check(desc_check),
		.tx_start_allow_r(tx_start_allow_r), .fn_reset_r(fn_reset_r),
		.tx_lower_bound_r(tx_lower_bound_r), .mdc_r(mdc_r),
		.mdio_out_r(mdio_out_r), .mdio_oe_n_r(mdio_oe_n_r),
		.mdio_in(mdio_in));
	emr_phy_model phy (.mdc_r(mdc_r), .mdio_out_r(mdio_out_r),
		.mdio_oe_n_r(mdio_oe_n_r), .mdio_in(mdio_in), .frame(frame),
		.nbits(nbits));
	// --------------------------------------------------------------
	// helpers
	// --------------------------------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value at %0t: seen %h expected %h", $time,
				seen, exp);
		end
	endtask
	task automatic tally_and_finish();
		if (err_total == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic wr(input logic [9:0] idx, input logic [7:0] d,
		input logic [1:0] er);
		@(posedge mclk);
		awaddr <= {idx, 2'b00};
		wdata <= {24'h000000, d};
		wstrb <= 4'hF;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		bq.push_back(er);
		forever begin
			@(posedge mclk);
			if (awvalid && awready)
				awvalid <= 0;
			if (wvalid && wready)
				wvalid <= 0;
			if (bvalid) begin
				bready <= 0;
				break;
			end
		end
	endtask
	// expected read result is noted, the monitor below compares it
	task automatic rd(input logic [9:0] idx, input logic [7:0] d,
		input logic [1:0] er);
		expq.push_back({er, 24'h000000, d});
		@(posedge mclk);
		araddr <= {idx, 2'b00};
		arvalid <= 1;
		rready <= 1;
		forever begin
			@(posedge mclk);
			if (arvalid && arready)
				arvalid <= 0;
			if (rvalid) begin
				rready <= 0;
				break;
			end
		end
	endtask
	always @(posedge mclk) begin
		if (rvalid && rready)
			check({rresp, rdata}, expq.pop_front());
	end
	// write response is compared at the edge it is accepted
	always @(posedge mclk) begin
		if (bvalid && bready)
			check(bresp, bq.pop_front());
	end
	always @(posedge mclk) begin
		if (desc_check) begin
			pulses++;
			gap = cyc - last;
			last = cyc;
		end
	end
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 30000) begin
			err_total++;
			tally_and_finish();
		end
	end
	// --------------------------------------------------------------
	// main sequence
	// --------------------------------------------------------------
	initial begin
		logic [9:0] ridx[6];
		logic [7:0] rmask[6];
		logic [7:0] rrst[6];
		logic [7:0] v;
		logic [4:0] u, r;
		logic [15:0] pd;
		int p0;
		ridx = '{emr_pkg::IDX_PHY_DATA_HIGH, emr_pkg::IDX_PHY_REG_SEL,
			emr_pkg::IDX_PHY_UNIT_SEL, emr_pkg::IDX_TX_POLL_PERIOD,
			emr_pkg::IDX_MAC_RESET_CTL, emr_pkg::IDX_TX_LOWER_LOW};
		rmask = '{8'hFF, 8'h1F, 8'h1F, 8'hFF, 8'h3F, 8'hE0};
		rrst = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h20, 8'h00};
		repeat (4) @(posedge mclk);
		rstn <= 1;
		check(fn_reset_r, 5'h1F);
		check(tx_start_allow_r, 1'b0);
		for (int i = 0; i < 6; i++)
			rd(ridx[i], rrst[i], emr_pkg::RESP_OKAY);
		rd(10'h050, 8'h00, emr_pkg::RESP_SLVERR);
		wr(10'h050, 8'h5A, emr_pkg::RESP_SLVERR);
		// fixed bits ignore writes, writable bits keep their value
		for (int i = 0; i < 6; i++) begin
			seed = lfsr(seed);
			v = seed[7:0] | 8'hE0;
			wr(ridx[i], v, emr_pkg::RESP_OKAY);
			rd(ridx[i], v & rmask[i],
				emr_pkg::RESP_OKAY);
			if (i == 5)
				check(tx_lower_bound_r, {8'h00, v & 8'hE0});
		end
		// each reset bit drives its function resets and stays put
		for (int b = 0; b < 6; b++) begin
			wr(emr_pkg::IDX_MAC_RESET_CTL, 8'h01 << b, emr_pkg::RESP_OKAY);
			repeat (20) @(posedge mclk);
			check(fn_reset_r,
				(b == 5) ? 5'h1F : 5'h01 << b);
		end
		// polling period is tick of 4 cycles times the register value
		wr(emr_pkg::IDX_TX_POLL_PERIOD, 8'h03, emr_pkg::RESP_OKAY);
		repeat (50) @(posedge mclk);
		check(gap, 12);
		check(tx_start_allow_r, 1'b1);
		@(posedge mclk iff desc_check);
		tx_busy <= 1;
		wr(emr_pkg::IDX_TX_POLL_PERIOD, 8'h00, emr_pkg::RESP_OKAY);
		// counted once the write is answered, before its check pulse shows,
		// so the pulse counter is not read at the edge it is bumped
		p0 = pulses;
		repeat (8) @(posedge mclk);
		check(tx_start_allow_r, 1'b1);
		tx_busy <= 0;
		repeat (60) @(posedge mclk);
		check(tx_start_allow_r, 1'b0);
		check(pulses - p0, 1);
		// management write frame
		seed = lfsr(seed);
		u = seed[4:0];
		r = seed[9:5];
		pd = seed[31:16];
		wr(emr_pkg::IDX_MAC_RESET_CTL, 8'h00, emr_pkg::RESP_OKAY);
		wr(emr_pkg::IDX_PHY_UNIT_SEL, {3'h0, u}, emr_pkg::RESP_OKAY);
		wr(emr_pkg::IDX_PHY_REG_SEL, {3'h0, r}, emr_pkg::RESP_OKAY);
		wr(emr_pkg::IDX_PHY_DATA_HIGH, pd[15:8], emr_pkg::RESP_OKAY);
		wr(emr_pkg::IDX_PHY_DATA_LOW, pd[7:0], emr_pkg::RESP_OKAY);
		wr(emr_pkg::IDX_MGMT_CMD, 8'h80, emr_pkg::RESP_OKAY);
		wr(emr_pkg::IDX_MGMT_CMD, 8'h80, emr_pkg::RESP_OKAY);
		// busy shows in status and command while the frame goes out
		rd(emr_pkg::IDX_MGMT_STATUS, 8'h01, emr_pkg::RESP_OKAY);
		rd(emr_pkg::IDX_MGMT_CMD, 8'h80, emr_pkg::RESP_OKAY);
		for (int t = 0; t < 600 && nbits < 64; t++)
			@(posedge mclk);
		repeat (20) @(posedge mclk);
		check(frame, {32'hFFFFFFFF, 4'h5, u, r, 2'h2, pd});
		check(nbits, 64);
		check(mdio_oe_n_r, 1'b1);
		check(expq.size() + bq.size(), 0);
		tally_and_finish();
	end
endmodule
